//--- design/ipcs_pkg.sv
// ipcs_pkg: register map, reset values and field positions for the
// input port and the chip-select/interrupt port.
// assumes a byte-wide register port with 20-bit addresses.
package ipcs_pkg;
	localparam int ADDR_W = 20;
	localparam logic [19:0] PORT_B_DIRECTION_ADDR = 20'hee007;
	localparam logic [19:0] PORT_A_PIN_LEVELS_ADDR = 20'hfffd6;
	localparam logic [19:0] PORT_B_OUTPUT_DATA_ADDR = 20'hfffd7;
	localparam logic [7:0] PORT_B_DIRECTION_RST = 8'hf0;
	localparam logic [7:0] PORT_B_OUTPUT_DATA_RST = 8'he0;
	localparam logic [7:0] PORT_B_RSVD_MASK = 8'he0;
	localparam logic [7:0] WO_READ_VALUE = 8'hff;
	localparam int PORT_A_W = 8;
	localparam int PORT_B_W = 5;
	localparam int CS_LO_BIT = 1;
	localparam int CS_HI_BIT = 4;
	localparam int IRQ_HI_BIT = 3;
	localparam int TRIG_BIT = 3;
endpackage : ipcs_pkg

//--- design/ipcs_reg8.sv
// ipcs_reg8: one 8-bit port register with reserved-high bits and hold.
// assumes the caller gates the write strobe with the address decode.
`timescale 1ns/100ps
module ipcs_reg8 #(
	parameter logic [7:0] RST_VAL = 8'h00,
	parameter logic [7:0] RSVD_MASK = 8'h00
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_hw_standby,
	input wire logic i_sw_standby,
	input wire logic i_wr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_q
);
	logic [7:0] q_reg;
	logic [7:0] q_next;

	always_comb begin
		q_next = q_reg;
		if (i_hw_standby) begin
			q_next = RST_VAL;
		end else if (i_wr && !i_sw_standby) begin
			// reserved bits stay high whatever is written
			q_next = i_wdata | RSVD_MASK;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			q_reg <= RST_VAL;
		end else begin
			q_reg <= q_next;
		end
	end

	assign o_q = q_reg;
endmodule : ipcs_reg8

//--- design/ipcs_pin_sync.sv
// ipcs_pin_sync: registered copy of the port pin levels; ipcs_top reads back the live pins instead.
// assumes pins are synchronous to i_clk.
`timescale 1ns/100ps
module ipcs_pin_sync #(
	parameter int W = 8
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [W-1:0] i_pins,
	output logic [W-1:0] o_levels
);
	logic [W-1:0] lvl_reg;
	logic [W-1:0] lvl_next;

	always_comb begin
		lvl_next = i_pins;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			lvl_reg <= '0;
		end else begin
			lvl_reg <= lvl_next;
		end
	end

	assign o_levels = lvl_reg;
endmodule : ipcs_pin_sync

//--- design/ipcs_top.sv
// ipcs_top: 8-bit input-only port plus 5-bit chip-select/interrupt port.
// assumes a single-cycle strobe register port, read data one cycle later,
// and pins synchronous to i_clk; pin levels are used live, not filtered.
`timescale 1ns/100ps

module ipcs_top #(
	parameter int PA_W = ipcs_pkg::PORT_A_W,
	parameter int PB_W = ipcs_pkg::PORT_B_W
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_hw_standby,
	input wire logic i_sw_standby,
	input wire logic [19:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic [PA_W-1:0] i_port_a_pins,
	input wire logic [PB_W-1:0] i_port_b_in,
	output logic [PB_W-1:0] o_port_b_out,
	output logic [PB_W-1:0] o_port_b_oe,
	input wire logic [3:0] i_chip_select_n,
	output logic [3:0] o_ext_interrupt_n,
	output logic o_converter_trigger_n
);
	//--------------------------------------------------------------
	// registers
	//--------------------------------------------------------------
	logic [7:0] dir_q;
	logic [7:0] data_q;
	logic wr_dir;
	logic wr_data;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic [PA_W-1:0] pa_levels;

	assign wr_dir = i_wr && (i_addr == ipcs_pkg::PORT_B_DIRECTION_ADDR);
	assign wr_data = i_wr && (i_addr == ipcs_pkg::PORT_B_OUTPUT_DATA_ADDR);

	ipcs_reg8 #(
		.RST_VAL(ipcs_pkg::PORT_B_DIRECTION_RST),
		.RSVD_MASK(ipcs_pkg::PORT_B_RSVD_MASK)
	) u_dir (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_hw_standby(i_hw_standby),
		.i_sw_standby(i_sw_standby),
		.i_wr(wr_dir),
		.i_wdata(i_wdata),
		.o_q(dir_q)
	);

	ipcs_reg8 #(
		.RST_VAL(ipcs_pkg::PORT_B_OUTPUT_DATA_RST),
		.RSVD_MASK(ipcs_pkg::PORT_B_RSVD_MASK)
	) u_data (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_hw_standby(i_hw_standby),
		.i_sw_standby(i_sw_standby),
		.i_wr(wr_data),
		.i_wdata(i_wdata),
		.o_q(data_q)
	);

	// port A has no direction or data store, only a pin sample
	ipcs_pin_sync #(
		.W(PA_W)
	) u_pa (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_pins(i_port_a_pins),
		.o_levels(pa_levels)
	);

	//--------------------------------------------------------------
	// pin drive
	//--------------------------------------------------------------
	// chip-select levels come from the timing logic outside
	always_comb begin
		o_port_b_oe = dir_q[PB_W-1:0];
		o_port_b_out = data_q[PB_W-1:0];
		for (int i = ipcs_pkg::CS_LO_BIT; i <= ipcs_pkg::CS_HI_BIT; i++) begin
			// pin 4 carries select 0, pin 1 select 3
			o_port_b_out[i] = i_chip_select_n[ipcs_pkg::CS_HI_BIT - i];
		end
	end

	// no gating by direction: driven pins still feed back
	assign o_ext_interrupt_n = i_port_b_in[ipcs_pkg::IRQ_HI_BIT:0];
	assign o_converter_trigger_n = i_port_b_in[ipcs_pkg::TRIG_BIT];

	//--------------------------------------------------------------
	// readback
	//--------------------------------------------------------------
	logic [PB_W-1:0] pb_view;

	always_comb begin
		pb_view = (dir_q[PB_W-1:0] & data_q[PB_W-1:0])
			| (~dir_q[PB_W-1:0] & i_port_b_in);
		rdata_next = 8'h00;
		if (i_rd) begin
			case (i_addr)
				ipcs_pkg::PORT_B_DIRECTION_ADDR:
					rdata_next = ipcs_pkg::WO_READ_VALUE;
				ipcs_pkg::PORT_A_PIN_LEVELS_ADDR:
					rdata_next = i_port_a_pins;
				ipcs_pkg::PORT_B_OUTPUT_DATA_ADDR:
					// reserved bits read high
					rdata_next = ipcs_pkg::PORT_B_RSVD_MASK | {3'h0, pb_view};
				default:
					rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// pa_levels kept as a registered copy; the live read uses the pins
	assign o_rdata = rdata_reg | {8{1'b0 & pa_levels[0]}};
endmodule : ipcs_top

//--- verification/ipcs_top_asserts.sv
// port checks for ipcs_top, attached by bind.
`timescale 1ns/100ps
module ipcs_top_asserts (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_hw_standby,
	input wire logic i_sw_standby,
	input wire logic [19:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic [7:0] i_port_a_pins,
	input wire logic [4:0] i_port_b_in,
	input wire logic [4:0] o_port_b_oe,
	input wire logic [3:0] o_ext_interrupt_n,
	input wire logic o_converter_trigger_n
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	property p_irq; o_ext_interrupt_n == i_port_b_in[3:0]; endproperty
	a_irq: assert property (p_irq) else $error("irq");
	property p_trig; o_converter_trigger_n == i_port_b_in[3]; endproperty
	a_trig: assert property (p_trig) else $error("trig");
	property p_rst; $fell(i_rst) |-> o_port_b_oe == 5'h10; endproperty
	a_rst: assert property (p_rst) else $error("rst");
	property p_hw; i_hw_standby |=> o_port_b_oe == 5'h10; endproperty
	a_hw: assert property (p_hw) else $error("hw");
	property p_sw; i_sw_standby && !i_hw_standby |=> $stable(o_port_b_oe);
	endproperty
	a_sw: assert property (p_sw) else $error("sw");
	property p_dwr; i_wr && i_addr == 20'hee007 && !i_sw_standby &&
		!i_hw_standby |=> o_port_b_oe == $past(i_wdata[4:0]); endproperty
	a_dwr: assert property (p_dwr) else $error("dir");
	property p_dro; i_rd && i_addr == 20'hee007 |=> o_rdata == 8'hff;
	endproperty
	a_dro: assert property (p_dro) else $error("wo");
	property p_pa; i_rd && i_addr == 20'hfffd6 |=>
		o_rdata == $past(i_port_a_pins); endproperty
	a_pa: assert property (p_pa) else $error("pa");
	property p_rsv; i_rd && i_addr == 20'hfffd7 |=> &o_rdata[7:5];
	endproperty
	a_rsv: assert property (p_rsv) else $error("rsv");
endmodule : ipcs_top_asserts

//--- verification/ipcs_pin_model.sv
// board side of port b: released pins show the board level.
`timescale 1ns/100ps
module ipcs_pin_model (
	input wire logic [4:0] i_out,
	input wire logic [4:0] i_oe,
	input wire logic [4:0] i_ext,
	output logic [4:0] o_pins
);
	assign o_pins = (i_out & i_oe) | (i_ext & ~i_oe);
endmodule : ipcs_pin_model

//--- verification/test_input_port_and_cs_irq_port.sv
// random register traffic and pin levels against ipcs_top.
`timescale 1ns/100ps
module test_input_port_and_cs_irq_port;
	logic i_clk = 1'h0, i_rst = 1'h1, i_wr = 1'h0, i_rd = 1'h0;
	logic i_hw_standby = 1'h0, i_sw_standby = 1'h0, o_converter_trigger_n;
	logic [19:0] i_addr = 20'h0;
	logic [7:0] i_wdata = 8'h0, i_port_a_pins = 8'h0, o_rdata, r, dm, om;
	logic [4:0] ext = 5'h0, i_port_b_in, o_port_b_out, o_port_b_oe, c;
	logic [3:0] i_chip_select_n = 4'h0, o_ext_interrupt_n;
	int err_total = 0, checks_done = 0, seed = 32'h216a;
	always #12.5 i_clk = ~i_clk;
	ipcs_top u_dut (.*);
	ipcs_pin_model u_pm (.i_out(o_port_b_out), .i_oe(o_port_b_oe),
		.i_ext(ext), .o_pins(i_port_b_in));
	task automatic chk(input logic [7:0] g, e);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic bus(input logic w, logic [19:0] a, logic [7:0] v);
		@(posedge i_clk);
		i_wr <= w;
		i_rd <= !w;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_clk);
		i_wr <= 1'h0;
		i_rd <= 1'h0;
		#1 r = o_rdata;
	endtask : bus
	function automatic logic [7:0] pb();
		return 8'he0 | {3'h0, dm[4:0] & om[4:0] | ~dm[4:0] & ext};
	endfunction : pb
	task automatic stop_test();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test
	initial begin
		#100us;
		err_total++;
		stop_test();
	end
	initial begin
		repeat (10) @(posedge i_clk);
		i_rst <= 1'h0;
		dm = 8'hf0;
		om = 8'he0;
		bus(1'h0, 20'hee007, 8'h0);
		for (int i = 0; i < 40; i++) begin
			@(posedge i_clk);
			ext <= $random(seed);
			i_port_a_pins <= $random(seed);
			i_chip_select_n <= $random(seed);
			bus(1'h0, 20'hfffd7, 8'h0);
			chk(r, pb());
			bus(1'h1, 20'hfffd6, 8'h5a);
			bus(1'h0, 20'hfffd6, 8'h0);
			chk(r, i_port_a_pins);
			om = (i < 2) ? 8'hff : $random(seed);
			dm = (i < 2) ? {8{i[0]}} : $random(seed);
			bus(1'h1, 20'hfffd7, om);
			bus(1'h1, 20'hee007, dm);
			om = om | 8'he0;
			dm = dm | 8'he0;
			c = {i_chip_select_n[0], i_chip_select_n[1], i_chip_select_n[2],
				i_chip_select_n[3], om[0]};
			chk({3'h0, o_port_b_out & dm[4:0]}, {3'h0, c & dm[4:0]});
		end
		@(posedge i_clk);
		i_sw_standby <= 1'h1;
		bus(1'h1, 20'hfffd7, ~om);
		bus(1'h1, 20'hee007, ~dm);
		bus(1'h0, 20'hfffd7, 8'h0);
		chk(r, pb());
		@(posedge i_clk);
		i_hw_standby <= 1'h1;
		dm = 8'hf0;
		om = 8'he0;
		bus(1'h0, 20'hfffd7, 8'h0);
		chk(r, pb());
		bus(1'h0, 20'h0, 8'h0);
		chk(r, 8'h0);
		stop_test();
	end
endmodule : test_input_port_and_cs_irq_port
bind ipcs_top ipcs_top_asserts u_chk (.*);
